//--- timer_pkg.sv
// Shared constants and types for the dual timer/counter block
package timer_pkg;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h88;
    localparam logic [7:0] TIMER_MODE_CONFIG_ADDR = 8'h89;
    localparam logic [7:0] TIMER0_LOW_ADDR = 8'h8a;
    localparam logic [7:0] TIMER1_LOW_ADDR = 8'h8b;
    localparam logic [7:0] TIMER0_HIGH_ADDR = 8'h8c;
    localparam logic [7:0] TIMER1_HIGH_ADDR = 8'h8d;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h90;
    localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h91;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h92;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int CTRL_RUN0_BIT = 4;
    localparam int CTRL_FLAG0_BIT = 5;
    localparam int CTRL_RUN1_BIT = 6;
    localparam int CTRL_FLAG1_BIT = 7;
    localparam int IRQ_TIMER0_BIT = 0;
    localparam int IRQ_TIMER1_BIT = 1;
    localparam logic [7:0] MODE_CONFIG_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // ********************************************************
    // Modes and timing
    // ********************************************************
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam int OSC_PERIODS_PER_MACHINE_CYCLE = 12;
    localparam int MACHINE_CYCLE_CLKS = OSC_PERIODS_PER_MACHINE_CYCLE;
    localparam logic [3:0] MC_LAST = 4'(MACHINE_CYCLE_CLKS - 1);

    // One nibble of the mode register (gate, source, mode)
    typedef struct packed {
        logic gate;
        logic counter_src;
        logic [1:0] mode;
    } timer_cfg_t;

    // High and low count bytes of one timer
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } count_pair_t;

endpackage : timer_pkg

//--- dual_timer_counter.sv
// Two 8-bit-machine style timer/counters with mode, control and interrupt registers
`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic GATE_PIN_A_I,
    input wire logic GATE_PIN_B_I,
    input wire logic EXT_COUNT_PIN_A_I,
    input wire logic EXT_COUNT_PIN_B_I,
    input wire logic VECTOR0_ACK_I,
    input wire logic VECTOR1_ACK_I,
    output logic IRQ_O,
    output logic TIMER0_OVERFLOW_FLAG_O,
    output logic TIMER1_OVERFLOW_FLAG_O,
    output logic BAUD_TICK_O
);

    // ********************************************************
    // Step function shared by both timers
    // ********************************************************

    // Returns {overflow, high, low} after one count event
    function automatic logic [16:0] count_step(
        input logic [1:0] mode,
        input logic [7:0] high,
        input logic [7:0] low
    );
        logic [5:0] pre;
        logic [8:0] lo_n;
        logic [8:0] hi_n;
        pre = {1'b0, low[4:0]} + 6'h01;
        lo_n = {1'b0, low} + 9'h001;
        hi_n = {1'b0, high};
        unique case (mode)
            timer_pkg::MODE_13BIT: begin
                if (pre[5]) begin
                    hi_n = {1'b0, high} + 9'h001;
                end
                count_step = {hi_n[8] & pre[5], hi_n[7:0], low[7:5], pre[4:0]};
            end
            timer_pkg::MODE_16BIT: begin
                if (lo_n[8]) begin
                    hi_n = {1'b0, high} + 9'h001;
                end
                count_step = {hi_n[8] & lo_n[8], hi_n[7:0], lo_n[7:0]};
            end
            timer_pkg::MODE_RELOAD: begin
                count_step = {lo_n[8], high, lo_n[8] ? high : lo_n[7:0]};
            end
            // Low byte as lone 8-bit counter
            default: begin
                count_step = {lo_n[8], high, lo_n[7:0]};
            end
        endcase
    endfunction : count_step

    // ********************************************************
    // State
    // ********************************************************
    logic [3:0] mc_count_q;
    logic mc_tick_q;
    logic [7:0] mode_cfg_q;
    logic run0_q;
    logic run1_q;
    logic flag0_q;
    logic flag1_q;
    logic pin_a_q;
    logic pin_b_q;
    timer_pkg::count_pair_t timer0_q;
    timer_pkg::count_pair_t timer1_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_enable_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic baud_q;

    timer_pkg::timer_cfg_t cfg0;
    timer_pkg::timer_cfg_t cfg1;
    logic split;
    logic fall_a;
    logic fall_b;
    logic en0;
    logic en1;
    logic en0_high;
    logic [16:0] step0;
    logic [16:0] step1;
    logic [8:0] high0_inc;
    logic ovf0;
    logic ovf1_timer;
    logic ovf0_high;
    logic ovf1_evt;
    logic wr_ctrl;

    // ********************************************************
    // Machine cycle divider
    // ********************************************************

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            mc_count_q <= 4'h0;
            mc_tick_q <= 1'b0;
        end else begin
            mc_tick_q <= (mc_count_q == timer_pkg::MC_LAST);
            if (mc_count_q == timer_pkg::MC_LAST) begin
                mc_count_q <= 4'h0;
            end else begin
                mc_count_q <= mc_count_q + 4'h1;
            end
        end
    end

    // ********************************************************
    // Count-pin sampling and enables
    // ********************************************************

    // Samples refresh only on the tick, so edges need one full cycle
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
        end else if (mc_tick_q) begin
            pin_a_q <= EXT_COUNT_PIN_A_I;
            pin_b_q <= EXT_COUNT_PIN_B_I;
        end
    end

    // Nibble split of the mode register
    assign cfg0 = timer_pkg::timer_cfg_t'(mode_cfg_q[3:0]);
    assign cfg1 = timer_pkg::timer_cfg_t'(mode_cfg_q[7:4]);
    assign split = (cfg0.mode == timer_pkg::MODE_SPLIT);
    // High sample followed by low sample
    assign fall_a = pin_a_q & ~EXT_COUNT_PIN_A_I;
    assign fall_b = pin_b_q & ~EXT_COUNT_PIN_B_I;

    // Enables; the gate bit of each nibble selects pin gating
    always_comb begin
        // Run, gate and source select for timer 0
        en0 = mc_tick_q & run0_q & (~cfg0.gate | GATE_PIN_A_I)
            & (cfg0.counter_src ? fall_a : 1'b1);
        // Timer 1 stops in its own mode 11; during split timer1_run is ignored
        en1 = mc_tick_q & (cfg1.mode != timer_pkg::MODE_SPLIT)
            & (split | run1_q) & (~cfg1.gate | GATE_PIN_B_I)
            & (cfg1.counter_src ? fall_b : 1'b1);
        // Split high byte counts machine cycles under timer1_run
        en0_high = mc_tick_q & split & run1_q;
    end

    // Next counts and overflow events
    always_comb begin
        step0 = count_step(cfg0.mode, timer0_q.high, timer0_q.low);
        step1 = count_step(cfg1.mode, timer1_q.high, timer1_q.low);
        high0_inc = {1'b0, timer0_q.high} + 9'h001;
        ovf0 = en0 & step0[16];
        ovf1_timer = en1 & step1[16];
        ovf0_high = en0_high & high0_inc[8];
        // In split mode the high byte owns the timer 1 flag
        ovf1_evt = split ? ovf0_high : ovf1_timer;
    end

    assign wr_ctrl = WR_I & (ADDR_I == timer_pkg::TIMER_CONTROL_ADDR);

    // ********************************************************
    // Count registers
    // ********************************************************

    // Timer 0 bytes; a software write wins over a count in the same cycle
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            timer0_q <= {timer_pkg::COUNT_RESET, timer_pkg::COUNT_RESET};
        end else begin
            // Only counting or writes change the bytes
            if (WR_I && ADDR_I == timer_pkg::TIMER0_LOW_ADDR) begin
                timer0_q.low <= WDATA_I;
            end else if (en0) begin
                timer0_q.low <= step0[7:0];
            end
            if (WR_I && ADDR_I == timer_pkg::TIMER0_HIGH_ADDR) begin
                timer0_q.high <= WDATA_I;
            end else if (en0_high) begin
                timer0_q.high <= high0_inc[7:0];
            end else if (en0 && !split) begin
                timer0_q.high <= step0[15:8];
            end
        end
    end

    // Timer 1 bytes
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            timer1_q <= {timer_pkg::COUNT_RESET, timer_pkg::COUNT_RESET};
        end else begin
            if (WR_I && ADDR_I == timer_pkg::TIMER1_LOW_ADDR) begin
                timer1_q.low <= WDATA_I;
            end else if (en1) begin
                timer1_q.low <= step1[7:0];
            end
            if (WR_I && ADDR_I == timer_pkg::TIMER1_HIGH_ADDR) begin
                timer1_q.high <= WDATA_I;
            end else if (en1) begin
                timer1_q.high <= step1[15:8];
            end
        end
    end

    // ********************************************************
    // Mode and control registers
    // ********************************************************

    // Mode register, plain read/write
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_cfg_q <= timer_pkg::MODE_CONFIG_RESET;
        end else if (WR_I && ADDR_I == timer_pkg::TIMER_MODE_CONFIG_ADDR) begin
            mode_cfg_q <= WDATA_I;
        end
    end

    // Run bits
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            run0_q <= 1'b0;
            run1_q <= 1'b0;
        end else if (wr_ctrl) begin
            run0_q <= WDATA_I[timer_pkg::CTRL_RUN0_BIT];
            run1_q <= WDATA_I[timer_pkg::CTRL_RUN1_BIT];
        end
    end

    // Overflow flags: hardware set beats both vector clear and software write
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            flag0_q <= 1'b0;
            flag1_q <= 1'b0;
        end else begin
            if (ovf0) begin
                flag0_q <= 1'b1;
            end else if (wr_ctrl) begin
                flag0_q <= WDATA_I[timer_pkg::CTRL_FLAG0_BIT];
            end else if (VECTOR0_ACK_I) begin
                // Cleared when the interrupt is vectored
                flag0_q <= 1'b0;
            end
            if (ovf1_evt) begin
                flag1_q <= 1'b1;
            end else if (wr_ctrl) begin
                flag1_q <= WDATA_I[timer_pkg::CTRL_FLAG1_BIT];
            end else if (VECTOR1_ACK_I) begin
                // Cleared when the interrupt is vectored
                flag1_q <= 1'b0;
            end
        end
    end

    // ********************************************************
    // Interrupt status, enable and output
    // ********************************************************

    // Sticky status; a new event outranks a clear in the same cycle
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_status_q <= timer_pkg::IRQ_RESET;
        end else begin
            if (ovf0) begin
                irq_status_q[timer_pkg::IRQ_TIMER0_BIT] <= 1'b1;
            end else if (WR_I && ADDR_I == timer_pkg::IRQ_CLEAR_ADDR
                         && WDATA_I[timer_pkg::IRQ_TIMER0_BIT]) begin
                irq_status_q[timer_pkg::IRQ_TIMER0_BIT] <= 1'b0;
            end
            if (ovf1_evt) begin
                irq_status_q[timer_pkg::IRQ_TIMER1_BIT] <= 1'b1;
            end else if (WR_I && ADDR_I == timer_pkg::IRQ_CLEAR_ADDR
                         && WDATA_I[timer_pkg::IRQ_TIMER1_BIT]) begin
                irq_status_q[timer_pkg::IRQ_TIMER1_BIT] <= 1'b0;
            end
        end
    end

    // Enable mask
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_enable_q <= timer_pkg::IRQ_RESET;
        end else if (WR_I && ADDR_I == timer_pkg::IRQ_ENABLE_ADDR) begin
            irq_enable_q <= WDATA_I[1:0];
        end
    end

    // Level output lags status by one clock to come from a flop
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_enable_q);
        end
    end

    // Timer 1 overflow pulse for the serial channel, even in split
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            baud_q <= 1'b0;
        end else begin
            baud_q <= ovf1_timer;
        end
    end

    // ********************************************************
    // Read port
    // ********************************************************

    // Data stands one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= 8'h00;
        end else if (RD_I) begin
            unique case (ADDR_I)
                timer_pkg::TIMER_CONTROL_ADDR:
                    rdata_q <= {flag1_q, run1_q, flag0_q, run0_q, 4'h0};
                timer_pkg::TIMER_MODE_CONFIG_ADDR: rdata_q <= mode_cfg_q;
                timer_pkg::TIMER0_LOW_ADDR: rdata_q <= timer0_q.low;
                timer_pkg::TIMER1_LOW_ADDR: rdata_q <= timer1_q.low;
                timer_pkg::TIMER0_HIGH_ADDR: rdata_q <= timer0_q.high;
                timer_pkg::TIMER1_HIGH_ADDR: rdata_q <= timer1_q.high;
                timer_pkg::IRQ_STATUS_ADDR: rdata_q <= {6'h00, irq_status_q};
                timer_pkg::IRQ_ENABLE_ADDR: rdata_q <= {6'h00, irq_enable_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign RDATA_O = rdata_q;
    assign IRQ_O = irq_q;
    assign TIMER0_OVERFLOW_FLAG_O = flag0_q;
    assign TIMER1_OVERFLOW_FLAG_O = flag1_q;
    assign BAUD_TICK_O = baud_q;

endmodule : dual_timer_counter

`default_nettype wire

//--- pin_partner.sv
// Pin-side model driving the gate pins and the external count pin
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] edges_i,
    input wire logic [1:0] gate_i,
    output logic gate_pin_a_o,
    output logic gate_pin_b_o,
    output logic count_pin_o,
    output logic busy_o
);
    logic [4:0] hold_q;
    logic [8:0] left_q;
    logic pin_q;

    // Gate levels follow the bench; count pin idles high between bursts
    assign gate_pin_a_o = gate_i[0];
    assign gate_pin_b_o = gate_i[1];
    assign count_pin_o = pin_q;
    assign busy_o = (left_q != 9'h000);

    // level hold time
    // Each level stands 24 clocks, twice the minimum, so any sampling phase sees it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_q <= 5'h00;
            left_q <= 9'h000;
            pin_q <= 1'b1;
        end else if (start_i) begin
            hold_q <= 5'h00;
            left_q <= {edges_i, 1'b0};
        end else if (busy_o) begin
            if (hold_q == 5'h17) begin
                hold_q <= 5'h00;
                left_q <= left_q - 9'h001;
                pin_q <= ~pin_q;
            end else begin
                hold_q <= hold_q + 5'h01;
            end
        end
    end
endmodule : pin_partner
`default_nettype wire

//--- dual_timer_counter_assertions.sv
// Port-level assertions for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter_checker (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic VECTOR0_ACK_I,
    input wire logic VECTOR1_ACK_I,
    input wire logic IRQ_O,
    input wire logic TIMER0_OVERFLOW_FLAG_O,
    input wire logic TIMER1_OVERFLOW_FLAG_O,
    input wire logic BAUD_TICK_O
);
    logic ctrl_wr;
    logic irq_wr;

    // Writes that may legally clear a flag or drop the interrupt
    assign ctrl_wr = WR_I && (ADDR_I == timer_pkg::TIMER_CONTROL_ADDR);
    assign irq_wr = WR_I && (ADDR_I == timer_pkg::IRQ_CLEAR_ADDR ||
                             ADDR_I == timer_pkg::IRQ_ENABLE_ADDR);

    default clocking @(posedge CLOCK_I);
    endclocking
    default disable iff (RST_I);

    // Mode register write, then its read back after one idle cycle
    sequence s_mode_wr;
        WR_I && ADDR_I == timer_pkg::TIMER_MODE_CONFIG_ADDR;
    endsequence
    sequence s_mode_rd;
        RD_I && ADDR_I == timer_pkg::TIMER_MODE_CONFIG_ADDR;
    endsequence

    // Bus, flag, interrupt and baud relations
    property p_read_idle; !$past(RD_I) |-> RDATA_O == 8'h00; endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not idle");
    property p_mode_rb;
        s_mode_wr ##1 !WR_I ##1 s_mode_rd |=> RDATA_O == $past(WDATA_I, 3);
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode read back wrong");
    property p_clr_rd;
        RD_I && ADDR_I == timer_pkg::IRQ_CLEAR_ADDR |=> RDATA_O == 8'h00;
    endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear register read not zero");
    property p_fl0_clr;
        $fell(TIMER0_OVERFLOW_FLAG_O) |-> $past(VECTOR0_ACK_I) || $past(ctrl_wr);
    endproperty
    a_fl0_clr: assert property (p_fl0_clr) else $error("flag 0 cleared unprompted");
    property p_fl1_clr;
        $fell(TIMER1_OVERFLOW_FLAG_O) |-> $past(VECTOR1_ACK_I) || $past(ctrl_wr);
    endproperty
    a_fl1_clr: assert property (p_fl1_clr) else $error("flag 1 cleared unprompted");
    property p_irq_up;
        $rose(IRQ_O) |-> $past(TIMER0_OVERFLOW_FLAG_O || TIMER1_OVERFLOW_FLAG_O)
            || $past(irq_wr, 2);
    endproperty
    a_irq_up: assert property (p_irq_up) else $error("interrupt rose without cause");
    property p_irq_dn; $fell(IRQ_O) |-> $past(irq_wr, 2); endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("interrupt fell without cause");
    property p_baud_gap; $rose(BAUD_TICK_O) |=> !BAUD_TICK_O [*8]; endproperty
    a_baud_gap: assert property (p_baud_gap) else $error("baud ticks too close");
endmodule : dual_timer_counter_checker

bind dual_timer_counter dual_timer_counter_checker checker_u (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .VECTOR0_ACK_I(VECTOR0_ACK_I),
    .VECTOR1_ACK_I(VECTOR1_ACK_I), .IRQ_O(IRQ_O), .BAUD_TICK_O(BAUD_TICK_O),
    .TIMER0_OVERFLOW_FLAG_O(TIMER0_OVERFLOW_FLAG_O),
    .TIMER1_OVERFLOW_FLAG_O(TIMER1_OVERFLOW_FLAG_O)
);
`default_nettype wire

//--- tb.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ack = 1'b0;
    logic start = 1'b0;
    logic [1:0] gate = 2'h3;
    logic [7:0] rdata;
    logic gpa, gpb, cpin, irq, fl0, fl1, baud, busy;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int baud_n = 0;
    int baud_mark = 0;
    // Timer, nibble, low, high, expected low, expected high, low mask, flag
    logic [63:0] tab [10] = '{
        64'h00_00_ff_ff_03_00_1f_01,
        64'h00_01_ff_ff_03_00_ff_01,
        64'h00_02_ff_fe_ff_fe_ff_01,
        64'h00_03_ff_55_03_55_ff_01,
        64'h01_01_ff_ff_03_00_ff_01,
        64'h01_03_ff_ff_ff_ff_ff_00,
        64'h00_09_ff_ff_ff_ff_ff_00,
        64'h01_09_ff_ff_ff_ff_ff_00,
        64'h00_09_ff_ff_03_00_ff_01,
        64'h01_02_ff_fe_ff_fe_ff_01
    };
    // Mapped registers, then one unmapped address
    logic [7:0] regs [10] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c,
                              8'h8d, 8'h90, 8'h91, 8'h92, 8'h80};

    dual_timer_counter dut (
        .CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .GATE_PIN_A_I(gpa), .GATE_PIN_B_I(gpb), .EXT_COUNT_PIN_A_I(cpin),
        .EXT_COUNT_PIN_B_I(cpin), .VECTOR0_ACK_I(ack), .VECTOR1_ACK_I(ack), .IRQ_O(irq),
        .TIMER0_OVERFLOW_FLAG_O(fl0), .TIMER1_OVERFLOW_FLAG_O(fl1), .BAUD_TICK_O(baud)
    );
    pin_partner partner (
        .clk_i(clk), .rst_i(rst), .start_i(start), .edges_i(8'h05), .gate_i(gate),
        .gate_pin_a_o(gpa), .gate_pin_b_o(gpb), .count_pin_o(cpin), .busy_o(busy)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    // Hang guard; the whole run needs under fifteen hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    // Baud pulses seen; each one-cycle pulse is counted once, at the edge that ends it
    always @(posedge clk) begin
        if (baud === 1'b1) begin
            baud_n <= baud_n + 1;
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk($sformatf("reg %h", a), rdata & msk, exp);
    endtask : rd_reg

    // Preload, run until overflow, stop exactly three ticks later, read back
    task automatic run_case(input logic [63:0] e);
        logic t;
        logic fl;
        t = e[56];
        fl = 1'b0;
        wr_reg(8'h8a + {7'h0, t}, e[47:40]);
        wr_reg(8'h8c + {7'h0, t}, e[39:32]);
        wr_reg(8'h89, t ? {e[51:48], 4'h0} : e[55:48]);
        wr_reg(8'h88, t ? 8'h40 : 8'h10);
        for (int n = 0; n < 30 && fl !== 1'b1; n++) begin
            @(posedge clk);
            fl = t ? fl1 : fl0;
        end
        chk("flag", {7'h0, fl}, e[7:0]);
        repeat (39) @(posedge clk);
        wr_reg(8'h88, 8'h00);
        rd_reg(8'h8a + {7'h0, t}, e[31:24], e[15:8]);
        rd_reg(8'h8c + {7'h0, t}, e[23:16], 8'hff);
    endtask : run_case

    task automatic complete_run();
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // Main sequence: reset values, modes, counter source, interrupt
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) begin
            rd_reg(regs[i], 8'h00, 8'hff);
        end
        wr_reg(8'h89, 8'ha5);
        rd_reg(8'h89, 8'ha5, 8'hff);
        foreach (tab[i]) begin
            gate <= (i == 6 || i == 7) ? 2'h0 : 2'h3;
            run_case(tab[i]);
        end
        gate <= 2'h3;
        // Five pin edges from 0xfffd: ticks alone would give a far larger count
        wr_reg(8'h8a, 8'hfd);
        wr_reg(8'h8c, 8'hff);
        wr_reg(8'h89, 8'h05);
        wr_reg(8'h88, 8'h10);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        for (int n = 0; n < 400 && busy === 1'b1; n++) @(posedge clk);
        repeat (24) @(posedge clk);
        chk("flag0", {7'h0, fl0}, 8'h01);
        wr_reg(8'h88, 8'h00);
        rd_reg(8'h8a, 8'h02, 8'hff);
        rd_reg(8'h8c, 8'h00, 8'hff);
        // Interrupt raise, mask, unmask, vector clear and status clear
        wr_reg(8'h91, 8'h03);
        rd_reg(8'h90, 8'h00, 8'hff);
        wr_reg(8'h92, 8'h01);
        wr_reg(8'h8a, 8'hff);
        wr_reg(8'h8c, 8'hff);
        wr_reg(8'h89, 8'h02);
        wr_reg(8'h88, 8'h10);
        repeat (30) @(posedge clk);
        chk("irq", {7'h0, irq}, 8'h01);
        rd_reg(8'h90, 8'h01, 8'hff);
        wr_reg(8'h92, 8'h00);
        repeat (2) @(posedge clk);
        chk("irq", {7'h0, irq}, 8'h00);
        wr_reg(8'h92, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq", {7'h0, irq}, 8'h01);
        wr_reg(8'h88, 8'h20);
        chk("flag0", {7'h0, fl0}, 8'h01);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(posedge clk);
        chk("flag0", {7'h0, fl0}, 8'h00);
        wr_reg(8'h91, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq", {7'h0, irq}, 8'h00);
        rd_reg(8'h90, 8'h00, 8'hff);
        // Split: timer1_run drives the high byte into flag 1, timer 1 still feeds baud
        baud_mark = baud_n;
        wr_reg(8'h8a, 8'h00);
        wr_reg(8'h8c, 8'hff);
        wr_reg(8'h8b, 8'hff);
        wr_reg(8'h8d, 8'hff);
        wr_reg(8'h89, 8'h23);
        wr_reg(8'h88, 8'h40);
        repeat (30) @(posedge clk);
        chk("flag1", {7'h0, fl1}, 8'h01);
        chk("flag0", {7'h0, fl0}, 8'h00);
        chk("baud", (baud_n != baud_mark) ? 8'h01 : 8'h00, 8'h01);
        // Stop the high byte but keep flag 1, then vector it away
        wr_reg(8'h88, 8'h80);
        chk("flag1", {7'h0, fl1}, 8'h01);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(posedge clk);
        chk("flag1", {7'h0, fl1}, 8'h00);
        rd_reg(8'h8a, 8'h00, 8'hff);
        rd_reg(8'h90, 8'h02, 8'hff);
        complete_run();
    end
endmodule : tb
`default_nettype wire
